// file: src/rss_pkg.sv
// Package for the rotate, subtract and skip datapath.
// Assumes one instruction clock shared with the core sequencer.
package rss_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int DATA_W    = 8;   // Data memory and working register
    localparam int WORD_W    = 15;  // Program memory word
    localparam int PROG_AW   = 12;  // Program memory address, 4K words
    localparam int PAGE_W    = 4;   // Page number part of the address
    localparam int TPTR_W    = 8;   // Table pointer, offset within a page
    localparam int BSEL_W    = 3;   // Bit number within a byte

    ////////////////////////////////////////////////////////////////////////
    // Field positions and fixed values
    localparam int       WORD_LO_MSB = 7;   // Low byte of a program word
    localparam int       WORD_HI_LSB = 8;   // High part of a program word
    localparam int       WORD_HI_W   = 7;   // Bits in the high part
    localparam int       NIB_MSB     = 3;   // Top bit of the low nibble
    localparam int       SIGN_BIT    = 7;   // Sign bit of a byte
    localparam logic [PAGE_W-1:0] LAST_PAGE = 4'hf;
    localparam logic [DATA_W-1:0] BYTE_ONES = 8'hff;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ONE  = 8'h01;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [DATA_W-1:0]  ACC_RST  = 8'h00;
    localparam logic [DATA_W-1:0]  TABLE_HIGH_LATCH_RST = 8'h00;
    localparam logic [PROG_AW-1:0] PADR_RST = 12'h000;

    ////////////////////////////////////////////////////////////////////////
    // Operations carried out by this datapath
    typedef enum logic [4:0] {
        OP_ROT_L,        // Rotate left, bit 7 into bit 0
        OP_ROT_R,        // Rotate right, bit 0 into bit 7
        OP_ROT_LC,       // Rotate left through borrow_inverse_bit
        OP_ROT_RC,       // Rotate right through borrow_inverse_bit
        OP_SUB,          // Subtract without borrow
        OP_SUB_B,        // Subtract with borrow
        OP_DEC_SKZ,      // Decrement, skip if zero
        OP_INC_SKZ,      // Increment, skip if zero
        OP_SKIP_BSET,    // Skip if selected bit is one
        OP_SKIP_BCLR,    // Skip if selected bit is zero
        OP_SKIP_ZERO,    // Skip if byte is zero
        OP_COPY_SKZ,     // Copy to working register, skip if zero
        OP_SET_BYTE,     // Byte to all ones
        OP_SET_BIT,      // Selected bit to one
        OP_SWAP,         // Exchange nibbles
        OP_TAB_CUR,      // Table read, current page
        OP_TAB_LAST,     // Table read, last page
        OP_XOR           // Exclusive-or
    } rss_op_t;

    // One instruction as handed over by the sequencer
    typedef struct packed {
        rss_op_t               op;
        logic                  to_acc;   // Copy form: result to register
        logic                  use_imm;  // Operand is immediate data
        logic [BSEL_W-1:0]     bit_sel;
        logic [DATA_W-1:0]     imm;
    } rss_req_t;

    // Status bits kept by this datapath
    typedef struct packed {
        logic signed_range;
        logic null_result;
        logic nibble_carry;
        logic borrow_inverse;
    } rss_flags_t;

    localparam rss_flags_t FLAGS_RST = '0;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DUMMY,
        ST_TBL_ADDR,
        ST_TBL_DATA
    } rss_state_t;

endpackage

// file: src/rss_datapath.sv
// Rotate, subtract, skip, set, swap, table read and exclusive-or datapath.
// Assumes the core presents the addressed data byte with each request,
// writes back through mem_wr_* to the same address, and serves program
// memory one cycle after prog_rd_en_q. All inputs share clk.
//
// Function
// - Rotate right, bit 0 into 7, flags kept
// - Rotate left through carry, carry takes bit 7
// - Rotate right through carry, carry takes bit 0
// - Copy forms write only the working register
// - Borrow subtract into working register
// - Borrow subtract into memory byte
// - Carry clear on negative, set otherwise
// - Subtractions update all four status bits
// - Plain subtract, memory or immediate operand
// - Decrement, write back, skip if zero
// - Decrement copy to register, skip if zero
// - Increment and skip if zero, flags kept
// - Taken skip costs a second dummy cycle
// - Skip when selected bit is one
// - Skip when selected bit is zero
// - Skip when byte is zero, nothing altered
// - Copy byte to register, skip if zero
// - Set byte to ones or one bit
// - Nibble swap in place or to register
// - Current page table read to memory, latch
// - Last page table read likewise
// - Exclusive-or, only zero flag changes
module rss_datapath
    import rss_pkg::*;
(
    // Clock, reset, enable
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               ce,
    // Instruction request
    input  wire logic               op_valid,
    input  wire rss_req_t           op_req,
    input  wire logic [DATA_W-1:0]  mem_rd_data,
    output logic                    op_ready_q,
    output logic                    done_q,
    output logic                    skip_q,
    // Data memory write back
    output logic                    mem_wr_en_q,
    output logic [DATA_W-1:0]       mem_wr_data_q,
    // Program memory for table reads
    input  wire logic [PROG_AW-1:0] pc,
    input  wire logic [TPTR_W-1:0]  table_pointer,
    input  wire logic [WORD_W-1:0]  prog_rd_data,
    output logic                    prog_rd_en_q,
    output logic [PROG_AW-1:0]      prog_addr_q,
    // Architectural state
    output logic [DATA_W-1:0]       working_register_q,
    output rss_flags_t              flags_q,
    output logic [DATA_W-1:0]       table_high_latch_q
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Byte is all zero
    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return v == BYTE_ZERO;
    endfunction

    // One-hot mask for a selected bit
    function automatic logic [DATA_W-1:0] bit_mask(
        input logic [BSEL_W-1:0] s);
        logic [DATA_W-1:0] m;
        m = BYTE_ZERO;
        m[s] = 1'b1;
        return m;
    endfunction

    // Operation belongs to the subtraction group
    function automatic logic is_sub(input rss_op_t o);
        return (o == OP_SUB) || (o == OP_SUB_B);
    endfunction

    // Operation is a table read
    function automatic logic is_tab(input rss_op_t o);
        return (o == OP_TAB_CUR) || (o == OP_TAB_LAST);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    rss_state_t          state_q;
    rss_state_t          state_d;
    logic [DATA_W-1:0]   acc_d;
    rss_flags_t          flags_d;
    logic                wr_en_d;
    logic [DATA_W-1:0]   wr_data_d;
    logic                skip_d;
    logic                done_d;

    ////////////////////////////////////////////////////////////////////////
    // Operand decode

    wire logic          accept   = ce && op_valid && op_ready_q;
    wire rss_op_t       op       = op_req.op;
    wire logic [DATA_W-1:0] m    = mem_rd_data;
    wire logic [DATA_W-1:0] acc  = working_register_q;
    wire logic          c_in     = flags_q.borrow_inverse;
    wire logic          sel_bit  = m[op_req.bit_sel];

    // Plain rotates and carry rotates
    wire logic [DATA_W-1:0] rot_l  = {m[6:0], m[7]};
    wire logic [DATA_W-1:0] rot_r  = {m[0], m[7:1]};
    wire logic [DATA_W-1:0] rot_lc = {m[6:0], c_in};
    wire logic [DATA_W-1:0] rot_rc = {c_in, m[7:1]};

    // Step, swap, set and exclusive-or results
    wire logic [DATA_W-1:0] dec_v  = m - BYTE_ONE;
    wire logic [DATA_W-1:0] inc_v  = m + BYTE_ONE;
    wire logic [DATA_W-1:0] swap_v = {m[3:0], m[7:4]};
    wire logic [DATA_W-1:0] sbit_v = m | bit_mask(op_req.bit_sel);
    wire logic [DATA_W-1:0] opd    = op_req.use_imm ? op_req.imm : m;
    wire logic [DATA_W-1:0] xor_v  = acc ^ opd;

    // Subtraction; borrow enters only for the borrow form
    wire logic          bw_in = (op == OP_SUB_B) && !c_in;
    wire logic [DATA_W:0] diff =
        {1'b0, acc} - {1'b0, opd} - {{DATA_W{1'b0}}, bw_in};
    wire logic [NIB_MSB+1:0] nib =
        {1'b0, acc[NIB_MSB:0]} - {1'b0, opd[NIB_MSB:0]}
        - {{NIB_MSB+1{1'b0}}, bw_in};
    wire logic [DATA_W-1:0] sub_v = diff[DATA_W-1:0];
    wire logic sub_ov = (acc[SIGN_BIT] != opd[SIGN_BIT])
                     && (sub_v[SIGN_BIT] != acc[SIGN_BIT]);

    ////////////////////////////////////////////////////////////////////////
    // Result selection

    function automatic logic [DATA_W-1:0] pick(input rss_op_t o);
        unique case (o)
            OP_ROT_L:     return rot_l;
            OP_ROT_R:     return rot_r;
            OP_ROT_LC:    return rot_lc;
            OP_ROT_RC:    return rot_rc;
            OP_SUB,
            OP_SUB_B:     return sub_v;
            OP_DEC_SKZ:   return dec_v;
            OP_INC_SKZ:   return inc_v;
            OP_SET_BYTE:  return BYTE_ONES;
            OP_SET_BIT:   return sbit_v;
            OP_SWAP:      return swap_v;
            OP_XOR:       return xor_v;
            default:      return m;   // Copy and test forms pass the byte
        endcase
    endfunction

    // A continuous call would wake only on op; this block also wakes on
    // every operand that the function reads
    logic [DATA_W-1:0] result;
    always_comb begin
        result = pick(op);
    end

    // Destination: register for copy forms, immediates, copy-skip
    wire logic has_dest = !(op inside {OP_SKIP_BSET, OP_SKIP_BCLR,
                                       OP_SKIP_ZERO, OP_TAB_CUR,
                                       OP_TAB_LAST});
    wire logic force_mem = (op == OP_SET_BYTE) || (op == OP_SET_BIT);
    wire logic dest_acc = (op == OP_COPY_SKZ)
                       || (op_req.to_acc && !force_mem)
                       || (op_req.use_imm && (is_sub(op)
                                              || op == OP_XOR));
    wire logic wr_acc = has_dest && dest_acc;
    wire logic wr_mem = has_dest && !dest_acc;

    // Skip conditions
    wire logic skip_hit =
        ((op == OP_DEC_SKZ) && is_zero(dec_v))
     || ((op == OP_INC_SKZ) && is_zero(inc_v))
     || ((op == OP_SKIP_BSET) && sel_bit)
     || ((op == OP_SKIP_BCLR) && !sel_bit)
     || ((op == OP_SKIP_ZERO) && is_zero(m))
     || ((op == OP_COPY_SKZ) && is_zero(m));

    // Table read address: page from program counter or last page
    wire logic [PAGE_W-1:0] tbl_page =
        (op == OP_TAB_LAST) ? LAST_PAGE
                            : pc[PROG_AW-1:PROG_AW-PAGE_W];
    wire logic [PROG_AW-1:0] tbl_addr = {tbl_page, table_pointer};

    ////////////////////////////////////////////////////////////////////////
    // Flag update

    always_comb begin
        flags_d = flags_q;
        if (accept && (state_q == ST_IDLE)) begin
            if (op == OP_ROT_LC) begin
                flags_d.borrow_inverse = m[7];
            end else if (op == OP_ROT_RC) begin
                flags_d.borrow_inverse = m[0];
            end else if (is_sub(op)) begin
                flags_d.borrow_inverse = !diff[DATA_W];
                flags_d.nibble_carry   = !nib[NIB_MSB+1];
                flags_d.signed_range   = sub_ov;
                flags_d.null_result    = is_zero(sub_v);
            end else if (op == OP_XOR) begin
                flags_d.null_result    = is_zero(xor_v);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencing and write back

    always_comb begin
        state_d   = state_q;
        acc_d     = working_register_q;
        wr_en_d   = 1'b0;
        wr_data_d = mem_wr_data_q;
        skip_d    = 1'b0;
        done_d    = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    if (is_tab(op)) begin
                        state_d = ST_TBL_ADDR;
                    end else begin
                        done_d  = 1'b1;
                        skip_d  = skip_hit;
                        wr_en_d = wr_mem;
                        if (wr_mem) begin
                            wr_data_d = result;
                        end
                        if (wr_acc) begin
                            acc_d = result;
                        end
                        if (skip_hit) begin
                            state_d = ST_DUMMY;
                        end
                    end
                end
            end
            ST_DUMMY: begin
                state_d = ST_IDLE;
            end
            ST_TBL_ADDR: begin
                state_d = ST_TBL_DATA;
            end
            ST_TBL_DATA: begin
                state_d   = ST_IDLE;
                done_d    = 1'b1;
                wr_en_d   = 1'b1;
                wr_data_d = prog_rd_data[WORD_LO_MSB:0];
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    // Sequencer and handshake
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= ST_IDLE;
            op_ready_q <= 1'b0;
            done_q     <= 1'b0;
            skip_q     <= 1'b0;
        end else if (ce) begin
            state_q    <= state_d;
            op_ready_q <= (state_d == ST_IDLE);
            done_q     <= done_d;
            skip_q     <= skip_d;
        end
    end

    // Working register and status bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            working_register_q <= ACC_RST;
            flags_q            <= FLAGS_RST;
        end else if (ce) begin
            working_register_q <= acc_d;
            flags_q            <= flags_d;
        end
    end

    // Data memory write back
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_wr_en_q   <= 1'b0;
            mem_wr_data_q <= BYTE_ZERO;
        end else if (ce) begin
            mem_wr_en_q   <= wr_en_d;
            mem_wr_data_q <= wr_data_d;
        end
    end

    // Program memory read strobe and address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_rd_en_q <= 1'b0;
            prog_addr_q  <= PADR_RST;
        end else if (ce) begin
            prog_rd_en_q <= (state_d == ST_TBL_ADDR);
            if (accept && (state_q == ST_IDLE) && is_tab(op)) begin
                prog_addr_q <= tbl_addr;
            end
        end
    end

    // High part of the table word; top bit is never used
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            table_high_latch_q <= TABLE_HIGH_LATCH_RST;
        end else if (ce && (state_q == ST_TBL_DATA)) begin
            table_high_latch_q <= {1'b0,
                prog_rd_data[WORD_HI_LSB +: WORD_HI_W]};
        end
    end

endmodule

// file: tb/rss_datapath_checker.sv
// Concurrent checks on the ports of the rotate, subtract, skip datapath.
// Assumes ce stays high in the bench; bound to every rss_datapath.
module rss_datapath_checker
    import rss_pkg::*;
(
    // Clock and reset
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic               ce,
    // Request side
    input wire logic               op_valid,
    input wire rss_req_t           op_req,
    input wire logic [DATA_W-1:0]  mem_rd_data,
    input wire logic               op_ready_q,
    input wire logic               done_q,
    input wire logic               skip_q,
    input wire logic               mem_wr_en_q,
    input wire logic [DATA_W-1:0]  mem_wr_data_q,
    // Program memory side
    input wire logic [PROG_AW-1:0] pc,
    input wire logic [TPTR_W-1:0]  table_pointer,
    input wire logic [WORD_W-1:0]  prog_rd_data,
    input wire logic               prog_rd_en_q,
    input wire logic [PROG_AW-1:0] prog_addr_q,
    // State
    input wire logic [DATA_W-1:0]  working_register_q,
    input wire rss_flags_t         flags_q,
    input wire logic [DATA_W-1:0]  table_high_latch_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Request accepted at this edge
    wire logic take;
    assign take = ce && op_valid && op_ready_q;

    ////////////////////////////////////////////////////////////////////////
    // Skip timing and table reads
    property p_skip_pair;
        skip_q |-> done_q && !op_ready_q ##1 op_ready_q;
    endproperty
    a_skip_pair: assert property (p_skip_pair)
        else $error("skip without dummy cycle");
    property p_tbl_last;
        take && op_req.op == OP_TAB_LAST |=> prog_rd_en_q &&
            prog_addr_q == {LAST_PAGE, $past(table_pointer)};
    endproperty
    a_tbl_last: assert property (p_tbl_last)
        else $error("last page address wrong");
    property p_tbl_done;
        prog_rd_en_q |-> !done_q ##2 done_q && mem_wr_en_q &&
            mem_wr_data_q == 8'($past(prog_rd_data));
    endproperty
    a_tbl_done: assert property (p_tbl_done)
        else $error("table low byte wrong");
    property p_tbl_latch;
        prog_rd_en_q |-> ##2
            table_high_latch_q == 8'($past(prog_rd_data) >> 8);
    endproperty
    a_tbl_latch: assert property (p_tbl_latch)
        else $error("table latch wrong");

    ////////////////////////////////////////////////////////////////////////
    // Results and flags
    property p_xor_mem;
        take && op_req.op == OP_XOR && !op_req.to_acc && !op_req.use_imm
        |=> mem_wr_en_q && mem_wr_data_q ==
            ($past(working_register_q) ^ $past(mem_rd_data)) &&
            flags_q.null_result == (mem_wr_data_q == 8'h00);
    endproperty
    a_xor_mem: assert property (p_xor_mem)
        else $error("xor to memory wrong");
    property p_no_flag;
        take && op_req.op inside {OP_ROT_L, OP_ROT_R, OP_SWAP, OP_SET_BYTE,
            OP_SET_BIT, OP_DEC_SKZ, OP_INC_SKZ} |=> $stable(flags_q);
    endproperty
    a_no_flag: assert property (p_no_flag)
        else $error("flags changed");
    property p_copy_nowr;
        take && op_req.to_acc && op_req.op inside {OP_ROT_L, OP_ROT_R,
            OP_ROT_LC, OP_ROT_RC, OP_SWAP} |=> !mem_wr_en_q;
    endproperty
    a_copy_nowr: assert property (p_copy_nowr)
        else $error("copy form wrote memory");
    property p_sub_carry;
        take && op_req.op == OP_SUB && !op_req.use_imm |=>
            flags_q.borrow_inverse ==
            ($past(working_register_q) >= $past(mem_rd_data));
    endproperty
    a_sub_carry: assert property (p_sub_carry)
        else $error("subtract carry wrong");
    property p_dec_mem;
        take && op_req.op == OP_DEC_SKZ && !op_req.to_acc |=> mem_wr_en_q &&
            mem_wr_data_q == $past(mem_rd_data) - 8'h01 &&
            skip_q == (mem_wr_data_q == 8'h00);
    endproperty
    a_dec_mem: assert property (p_dec_mem)
        else $error("decrement skip wrong");
endmodule

bind rss_datapath rss_datapath_checker rss_datapath_checker_inst (
    .clk, .rst_n, .ce, .op_valid, .op_req, .mem_rd_data, .op_ready_q,
    .done_q, .skip_q, .mem_wr_en_q, .mem_wr_data_q, .pc, .table_pointer,
    .prog_rd_data, .prog_rd_en_q, .prog_addr_q, .working_register_q,
    .flags_q, .table_high_latch_q
);

// file: tb/tb_rss_datapath.sv
// Self-checking bench for the rotate, subtract, skip datapath.
// The bench plays the core: data byte, program memory, clock enable.
module tb_rss_datapath;
    import rss_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // Design ports
    logic clk, rst_n, ce, op_valid, op_ready_q, done_q, skip_q, mem_wr_en_q;
    logic prog_rd_en_q;
    rss_req_t op_req;
    rss_flags_t flags_q;
    logic [7:0]  mem_rd_data, mem_wr_data_q, table_pointer;
    logic [7:0]  working_register_q, table_high_latch_q;
    logic [11:0] pc, prog_addr_q, addr_seen;
    logic [14:0] prog_rd_data, rom_w;
    // Bench state
    logic got_skip, got_wr, got_rdy, exp_c;
    int n_errors, tests_run;

    rss_datapath rss_datapath_inst (.clk, .rst_n, .ce, .op_valid, .op_req,
        .mem_rd_data, .op_ready_q, .done_q, .skip_q, .mem_wr_en_q,
        .mem_wr_data_q, .pc, .table_pointer, .prog_rd_data, .prog_rd_en_q,
        .prog_addr_q, .working_register_q, .flags_q, .table_high_latch_q);

    // Clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare, verdict
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One instruction: wait ready, present, serve program memory, wait done
    task automatic run(rss_op_t op, logic ta, logic ui, logic [2:0] bs,
                       logic [7:0] im, logic [7:0] md);
        int k;
        k = 0;
        @(negedge clk);
        while (op_ready_q !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        op_valid = 1'b1;
        op_req = '{op, ta, ui, bs, im};
        mem_rd_data = md;
        @(negedge clk);
        op_valid = 1'b0;
        mem_rd_data = ~md;
        k = 0;
        while (done_q !== 1'b1 && k < 8) begin
            if (prog_rd_en_q === 1'b1) begin
                addr_seen = prog_addr_q;
                prog_rd_data = rom_w;
            end
            @(negedge clk);
            k++;
        end
        if (k == 8) chk("done", 16'h1, 16'h0);
        got_skip = skip_q;
        got_wr = mem_wr_en_q;
        got_rdy = op_ready_q;
        prog_rd_data = ~prog_rd_data;
    endtask
    // Run and compare skip, write, ready and the value at its destination
    task automatic expect_op(string n, rss_op_t op, logic ta, logic [2:0] bs,
                             logic [7:0] md, logic sk, logic wr, logic [7:0] v);
        run(op, ta, 1'b0, bs, md, md);
        chk({n, " skip"}, 16'(sk), 16'(got_skip));
        chk({n, " write"}, 16'(wr), 16'(got_wr));
        chk({n, " ready"}, 16'(!sk), 16'(got_rdy));
        chk({n, " value"}, 16'(v),
            16'(wr ? mem_wr_data_q : working_register_q));
    endtask
    // Subtract with expected flags worked out here
    task automatic sub(rss_op_t op, logic ta, logic ui, logic [7:0] a,
                       logic [7:0] b);
        logic [8:0] d;
        logic [4:0] nb;
        logic bin;
        bin = (op == OP_SUB_B) ? !exp_c : 1'b0;
        d = {1'b0, a} - {1'b0, b} - 9'(bin);
        nb = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(bin);
        run(OP_COPY_SKZ, 1'b1, 1'b0, 3'h0, 8'h00, a);
        run(op, ta, ui, 3'h0, b, b);
        chk("sub value", 16'(d[7:0]), 16'((ta || ui) ? working_register_q
            : mem_wr_data_q));
        chk("sub flags", 16'({(a[7] ^ b[7]) & (d[7] ^ a[7]), d[7:0] == 8'h00,
            !nb[4], !d[8]}), 16'(flags_q));
        exp_c = !d[8];
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog, well beyond the fewer than a hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        chk("watchdog", 16'h0, 16'h1);
        tally_and_finish();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0; ce = 1'b1; op_valid = 1'b0; op_req = '0;
        mem_rd_data = 8'h00; pc = 12'h3a5; table_pointer = 8'h44;
        prog_rd_data = 15'h0000; rom_w = 15'h5abc; exp_c = 1'b0;
        n_errors = 0; tests_run = 0;
        repeat (3) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        expect_op("rrc", OP_ROT_RC, 1, 0, 8'h01, 0, 0, 8'h00);
        chk("carry", 16'h1, 16'(flags_q.borrow_inverse));
        expect_op("rlc", OP_ROT_LC, 0, 0, 8'h81, 0, 1, 8'h03);
        expect_op("rotate_right_thru_carry_copy", OP_ROT_RC, 1, 0, 8'h02, 0, 0, 8'h81);
        expect_op("rr", OP_ROT_R, 0, 0, 8'h01, 0, 1, 8'h80);
        expect_op("rra", OP_ROT_R, 1, 0, 8'h03, 0, 0, 8'h81);
        expect_op("rla", OP_ROT_L, 1, 0, 8'h80, 0, 0, 8'h01);
        chk("rot flags", 16'h0, 16'(flags_q));
        $display("test rotate done");
        sub(OP_SUB, 1, 1, 8'h10, 8'h01);
        sub(OP_SUB, 1, 0, 8'h00, 8'h01);
        sub(OP_SUB_B, 0, 0, 8'h80, 8'h01);
        sub(OP_SUB_B, 1, 0, 8'h05, 8'h05);
        sub(OP_SUB, 0, 0, 8'h05, 8'h05);
        $display("test subtract done");
        expect_op("dz", OP_DEC_SKZ, 0, 0, 8'h01, 1, 1, 8'h00);
        expect_op("dza", OP_DEC_SKZ, 1, 0, 8'h02, 0, 0, 8'h01);
        expect_op("iz", OP_INC_SKZ, 0, 0, 8'hff, 1, 1, 8'h00);
        expect_op("iza", OP_INC_SKZ, 1, 0, 8'hfe, 0, 0, 8'hff);
        expect_op("bs1", OP_SKIP_BSET, 0, 3, 8'h08, 1, 0, 8'hff);
        expect_op("bs0", OP_SKIP_BSET, 0, 2, 8'h08, 0, 0, 8'hff);
        expect_op("bc1", OP_SKIP_BCLR, 0, 3, 8'hf7, 1, 0, 8'hff);
        expect_op("bc0", OP_SKIP_BCLR, 0, 7, 8'hf7, 0, 0, 8'hff);
        expect_op("z1", OP_SKIP_ZERO, 0, 0, 8'h00, 1, 0, 8'hff);
        expect_op("z0", OP_SKIP_ZERO, 0, 0, 8'h01, 0, 0, 8'hff);
        expect_op("cz", OP_COPY_SKZ, 1, 0, 8'h00, 1, 0, 8'h00);
        expect_op("cn", OP_COPY_SKZ, 1, 0, 8'h5a, 0, 0, 8'h5a);
        $display("test skip done");
        expect_op("setb", OP_SET_BYTE, 0, 0, 8'h12, 0, 1, 8'hff);
        expect_op("seti", OP_SET_BIT, 0, 5, 8'h00, 0, 1, 8'h20);
        expect_op("swp", OP_SWAP, 0, 0, 8'h3c, 0, 1, 8'hc3);
        expect_op("swpa", OP_SWAP, 1, 0, 8'ha5, 0, 0, 8'h5a);
        run(OP_XOR, 1'b0, 1'b1, 3'h0, 8'h5a, 8'h5a);
        chk("xor imm", 16'h0, 16'(working_register_q));
        chk("xor zero", 16'h1, 16'(flags_q.null_result));
        run(OP_COPY_SKZ, 1'b1, 1'b0, 3'h0, 8'h00, 8'h5a);
        expect_op("exclusive_or_to_mem", OP_XOR, 0, 0, 8'h0f, 0, 1, 8'h55);
        chk("xor flags", 16'h3, 16'(flags_q));
        $display("test set swap xor done");
        expect_op("tc", OP_TAB_CUR, 0, 0, 8'h00, 0, 1, 8'hbc);
        chk("tc addr", 16'h344, 16'(addr_seen));
        chk("tc latch", 16'h5a, 16'(table_high_latch_q));
        table_pointer = 8'hff;
        rom_w = 15'h7f01;
        expect_op("tl", OP_TAB_LAST, 0, 0, 8'h00, 0, 1, 8'h01);
        chk("tl addr", 16'hfff, 16'(addr_seen));
        chk("tl latch", 16'h7f, 16'(table_high_latch_q));
        $display("test table done");
        tally_and_finish();
    end
endmodule
